/* File: logic/asd_core.sv */
// Sleep and SMART command dispatcher with AXI4-Lite task-file registers
// What this block does
// RL1 - Either sleep opcode starts entry into the sleep power state.
// RL2 - Sleep stops the spindle first, then makes the host interface inactive.
// RL3 - Sleep with the spindle already stopped goes straight to sleep.
// RL4 - Sleep ends only by software or hardware reset; host must issue one.
// RL5 - The SMART opcode is the entry point for all SMART subcommands.
// RL6 - Host loads the subcommand code into Features before writing the opcode.
// RL7 - Codes D0h-D6h and D8h-DBh select subcommands; others abort.
// RL8 - Read values saves attributes first, then sends a 512-byte block.
// RL9 - Read thresholds fetches threshold sectors, then sends a 512-byte block.
// RL10 - SMART needs key 4Fh/C2h in cylinder registers; device bit selects target.
// RL11 - Completion clears busy and fault; abort sets abort bit and error status.
`timescale 1ns/10ps
module asd_core #(
  parameter logic DEVICE_NUM = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic spindle_stopped,
  output logic spindle_stop,
  output logic interface_inactive,
  output logic attr_save_req,
  input wire logic attr_save_done,
  output logic thr_fetch_req,
  input wire logic thr_fetch_done,
  output logic sector_rd_en,
  output logic sector_sel,
  output logic [6:0] sector_rd_addr,
  input wire logic [31:0] sector_rd_data
);
  typedef struct packed {
    asd_pkg::asd_state_e state;
    logic [7:0] feature, sec_count, sec_number, cyl_low;
    logic [7:0] cyl_high, target, error;
    logic abort_st, srst, aw_got;
    logic [11:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] wcnt;
    logic issued, hold_v;
    logic [31:0] hold;
    logic thr_sel, save_req, fetch_req, spin_req;
  } asd_core_s;

  asd_core_s r;
  asd_core_s next_r;
  logic stopped_s, cmd_go, key_ok, busy, rd_go;
  logic [7:0] cmd_op, status;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [31:0] fifo_out_data;

  // Address map check shared by the read and write paths
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a <= asd_pkg::OFS_DEVCTL) && (a[1:0] == 2'h0);
  endfunction

  // The spindle level comes from the motor controller, outside this clock
  asd_sync u_stop_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ce(ce),
    .din(spindle_stopped),
    .dout(stopped_s)
  );

  // Sector words wait here until software drains the data port
  asd_fifo #(
    .WIDTH(asd_pkg::FIFO_WIDTH),
    .DEPTH(asd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ce(ce),
    .flush(r.srst),
    .in_valid(r.hold_v),
    .in_ready(fifo_in_ready),
    .in_data(r.hold),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  // Status byte is built live from the sequencer state
  assign busy = r.srst || (r.state == asd_pkg::ASD_SPIN_DOWN) ||
                (r.state == asd_pkg::ASD_SAVE) || (r.state == asd_pkg::ASD_FETCH) ||
                (r.state == asd_pkg::ASD_STREAM);
  always_comb begin
    status = 8'h00;
    status[asd_pkg::ST_BUSY] = busy; // [RL11]
    status[asd_pkg::ST_READY] = !busy && (r.state != asd_pkg::ASD_SLEEP);
    status[asd_pkg::ST_FAULT] = 1'b0; // [RL11]
    status[asd_pkg::ST_SEEK] = (r.state != asd_pkg::ASD_SLEEP);
    status[asd_pkg::ST_DRQ] = fifo_out_valid;
    status[asd_pkg::ST_ERR] = r.abort_st; // [RL11]
  end

  // Key check uses what the host loaded before the opcode
  assign key_ok = (r.cyl_low == asd_pkg::KEY_CYL_LOW) &&
                  (r.cyl_high == asd_pkg::KEY_CYL_HIGH); // [RL10]
  assign cmd_op = r.w_data[7:0];
  // A command launches only from idle, for this device, outside soft reset
  assign cmd_go = r.aw_got && r.w_got && (r.aw_addr == asd_pkg::OFS_OPCODE) &&
                  r.w_strb[0] && (r.state == asd_pkg::ASD_IDLE) && !r.srst &&
                  (r.target[asd_pkg::TGT_DEV] == DEVICE_NUM); // [RL10]

  // One word fetch in flight at a time; simple, at some cost in throughput
  assign rd_go = (r.state == asd_pkg::ASD_STREAM) && !r.issued && !r.hold_v &&
                 (r.wcnt < asd_pkg::SECTOR_WORDS);

  // Next-state logic: bus slave, command decode and sequencer
  always_comb begin
    next_r = r;
    fifo_pop = 1'b0;
    // Write address and data are taken independently, in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.aw_got = 1'b1;
      next_r.aw_addr = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.w_got = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (r.aw_got && r.w_got) begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = is_mapped(r.aw_addr) ? asd_pkg::RESP_OKAY : asd_pkg::RESP_SLVERR;
      // Asleep, only the device control register still listens
      if (r.w_strb[0] && (r.state != asd_pkg::ASD_SLEEP)) begin // [RL2]
        case (r.aw_addr)
          asd_pkg::OFS_FEATURE: next_r.feature = r.w_data[7:0]; // [RL6]
          asd_pkg::OFS_SEC_COUNT: next_r.sec_count = r.w_data[7:0];
          asd_pkg::OFS_SEC_NUMBER: next_r.sec_number = r.w_data[7:0];
          asd_pkg::OFS_CYL_LOW: next_r.cyl_low = r.w_data[7:0];
          asd_pkg::OFS_CYL_HIGH: next_r.cyl_high = r.w_data[7:0];
          asd_pkg::OFS_TARGET: next_r.target = r.w_data[7:0];
          default: begin
          end
        endcase
      end
      if (r.w_strb[0] && (r.aw_addr == asd_pkg::OFS_DEVCTL)) begin
        next_r.srst = r.w_data[asd_pkg::CTL_SRST]; // [RL4]
      end
    end

    // Command decode; the subcommand is whatever Features holds now
    if (cmd_go) begin
      next_r.error = asd_pkg::RST_BYTE;
      next_r.abort_st = 1'b0;
      if ((cmd_op == asd_pkg::OPC_SLEEP_A) || (cmd_op == asd_pkg::OPC_SLEEP_B)) begin // [RL1]
        next_r.spin_req = 1'b1;
        if (stopped_s) begin
          next_r.state = asd_pkg::ASD_SLEEP; // [RL3]
        end else begin
          next_r.state = asd_pkg::ASD_SPIN_DOWN; // [RL2]
        end
      end else if (cmd_op == asd_pkg::OPC_SMART) begin // [RL5]
        if (!key_ok || !asd_pkg::asd_valid_sub(r.feature)) begin // [RL7] [RL10]
          next_r.error = asd_pkg::ERR_ABORT_VAL; // [RL11]
          next_r.abort_st = 1'b1;
        end else if (r.feature == asd_pkg::SUB_READ_VALUES) begin
          next_r.state = asd_pkg::ASD_SAVE; // [RL8]
          next_r.save_req = 1'b1;
          next_r.thr_sel = 1'b0;
        end else if (r.feature == asd_pkg::SUB_READ_THRESH) begin
          next_r.state = asd_pkg::ASD_FETCH; // [RL9]
          next_r.fetch_req = 1'b1;
          next_r.thr_sel = 1'b1;
        end
      end else begin
        next_r.error = asd_pkg::ERR_ABORT_VAL; // [RL11]
        next_r.abort_st = 1'b1;
      end
    end

    // Sequencer
    case (r.state)
      asd_pkg::ASD_IDLE: begin
      end
      asd_pkg::ASD_SPIN_DOWN: begin
        if (stopped_s) begin
          next_r.state = asd_pkg::ASD_SLEEP; // [RL2]
        end
      end
      asd_pkg::ASD_SLEEP: begin
        // Held here; only the soft reset below or reset_n leaves
      end
      asd_pkg::ASD_SAVE: begin
        if (attr_save_done) begin
          next_r.save_req = 1'b0;
          next_r.state = asd_pkg::ASD_STREAM; // [RL8]
          next_r.wcnt = 8'h00;
        end
      end
      asd_pkg::ASD_FETCH: begin
        if (thr_fetch_done) begin
          next_r.fetch_req = 1'b0;
          next_r.state = asd_pkg::ASD_STREAM; // [RL9]
          next_r.wcnt = 8'h00;
        end
      end
      asd_pkg::ASD_STREAM: begin
        if (r.hold_v && fifo_in_ready) begin
          next_r.hold_v = 1'b0;
        end
        if (r.issued) begin
          next_r.issued = 1'b0;
          next_r.hold = sector_rd_data;
          next_r.hold_v = 1'b1;
          next_r.wcnt = r.wcnt + 8'h01;
        end
        if (rd_go) begin
          next_r.issued = 1'b1;
        end
        // Busy drops once the last word has entered the FIFO
        if ((r.wcnt == asd_pkg::SECTOR_WORDS) && !r.hold_v && !r.issued) begin
          next_r.state = asd_pkg::ASD_IDLE; // [RL8] [RL9] [RL11]
        end
      end
      default: next_r.state = asd_pkg::ASD_IDLE;
    endcase

    // Soft reset aborts any sequence and wakes a sleeping drive
    if (r.srst) begin
      next_r.state = asd_pkg::ASD_IDLE; // [RL4]
      next_r.error = asd_pkg::RST_BYTE;
      next_r.abort_st = 1'b0;
      next_r.save_req = 1'b0;
      next_r.fetch_req = 1'b0;
      next_r.spin_req = 1'b0;
      next_r.issued = 1'b0;
      next_r.hold_v = 1'b0;
    end

    // Read channel; a data port read pops one FIFO word
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = is_mapped(s_axi_araddr[11:0]) ?
                     asd_pkg::RESP_OKAY : asd_pkg::RESP_SLVERR;
      next_r.rdata = 32'h0000_0000;
      case (s_axi_araddr[11:0])
        asd_pkg::OFS_FEATURE: next_r.rdata[7:0] = r.feature;
        asd_pkg::OFS_SEC_COUNT: next_r.rdata[7:0] = r.sec_count;
        asd_pkg::OFS_SEC_NUMBER: next_r.rdata[7:0] = r.sec_number;
        asd_pkg::OFS_CYL_LOW: next_r.rdata[7:0] = r.cyl_low;
        asd_pkg::OFS_CYL_HIGH: next_r.rdata[7:0] = r.cyl_high;
        asd_pkg::OFS_TARGET: next_r.rdata[7:0] = r.target;
        asd_pkg::OFS_STATUS: next_r.rdata[7:0] = status;
        asd_pkg::OFS_ERROR: next_r.rdata[7:0] = r.error;
        asd_pkg::OFS_DEVCTL: next_r.rdata[asd_pkg::CTL_SRST] = r.srst;
        asd_pkg::OFS_DATA: begin
          next_r.rdata = fifo_out_data;
          fifo_pop = fifo_out_valid;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  // Ports; the write path refuses a new address or word until B is taken
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid && ce;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign spindle_stop = r.spin_req;
  assign interface_inactive = (r.state == asd_pkg::ASD_SLEEP);
  assign attr_save_req = r.save_req;
  assign thr_fetch_req = r.fetch_req;
  assign sector_rd_en = rd_go && ce;
  assign sector_sel = r.thr_sel;
  assign sector_rd_addr = r.wcnt[6:0];

  // Checks on the sequencer
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_sleep_go;
    ce && cmd_go && ((cmd_op == asd_pkg::OPC_SLEEP_A) || (cmd_op == asd_pkg::OPC_SLEEP_B));
  endsequence
  sequence s_smart_go;
    ce && cmd_go && (cmd_op == asd_pkg::OPC_SMART) && key_ok;
  endsequence
  sequence s_saved;
    ce && !r.srst && (r.state == asd_pkg::ASD_SAVE) && attr_save_done;
  endsequence

  a_sleep_entry: assert property (s_sleep_go |=> // [RL1]
    (r.state == asd_pkg::ASD_SPIN_DOWN) || (r.state == asd_pkg::ASD_SLEEP))
    else $error("sleep opcode did not start sleep entry");
  a_spin_first: assert property (ce && !r.srst && (r.state == asd_pkg::ASD_SPIN_DOWN) && // [RL2]
    !stopped_s |=> (r.state == asd_pkg::ASD_SPIN_DOWN) && spindle_stop)
    else $error("left spin down before spindle stopped");
  a_skip_spin: assert property (s_sleep_go and stopped_s |=> // [RL3]
    interface_inactive && spindle_stop)
    else $error("stopped spindle did not go straight to sleep");
  a_sleep_holds: assert property (ce && interface_inactive && !next_r.srst |=> // [RL4]
    interface_inactive)
    else $error("sleep left without reset");
  a_values_save: assert property (s_smart_go and (r.feature == asd_pkg::SUB_READ_VALUES) // [RL5]
    |=> (r.state == asd_pkg::ASD_SAVE) && attr_save_req && !sector_sel)
    else $error("read values did not start attribute save");
  a_bad_sub: assert property (s_smart_go and !asd_pkg::asd_valid_sub(r.feature) |=> // [RL7]
    (r.error == asd_pkg::ERR_ABORT_VAL) && status[asd_pkg::ST_ERR] && !busy)
    else $error("invalid subcommand not aborted");
  a_save_then_send: assert property (s_saved |=> // [RL8]
    (r.state == asd_pkg::ASD_STREAM) && (r.wcnt == 8'h00) ##0 !attr_save_req)
    else $error("stream did not follow the attribute save");
  a_thresh_fetch: assert property (s_smart_go and (r.feature == asd_pkg::SUB_READ_THRESH) // [RL9]
    |=> thr_fetch_req && sector_sel ##0 (r.state == asd_pkg::ASD_FETCH))
    else $error("read thresholds did not start the fetch");
  a_block_len: assert property (ce && !r.srst && (r.state == asd_pkg::ASD_STREAM) && // [RL8]
    (next_r.state == asd_pkg::ASD_IDLE) |-> (r.wcnt == asd_pkg::SECTOR_WORDS))
    else $error("sector block ended short of 512 bytes");
  a_key_guard: assert property (ce && cmd_go && (cmd_op == asd_pkg::OPC_SMART) && // [RL10]
    !key_ok |=> r.abort_st && (r.state == asd_pkg::ASD_IDLE))
    else $error("SMART without key not aborted");
  a_done_clear: assert property (ce && !r.srst && !next_r.srst && // [RL11]
    (r.state == asd_pkg::ASD_STREAM) ##1
    (r.state == asd_pkg::ASD_IDLE) |-> !status[asd_pkg::ST_BUSY] && !status[asd_pkg::ST_FAULT])
    else $error("completion left busy or fault set");
endmodule

/* File: logic/asd_pkg.sv */
// Shared constants, register map and state type of the sleep and SMART dispatcher
package asd_pkg;
  // Command opcodes
  localparam logic [7:0] OPC_SLEEP_A = 8'he6;
  localparam logic [7:0] OPC_SLEEP_B = 8'h99;
  localparam logic [7:0] OPC_SMART = 8'hb0;

  // SMART subcommand codes and their two valid ranges
  localparam logic [7:0] SUB_READ_VALUES = 8'hd0;
  localparam logic [7:0] SUB_READ_THRESH = 8'hd1;
  localparam logic [7:0] SUB_LOW_LAST = 8'hd6;
  localparam logic [7:0] SUB_HIGH_FIRST = 8'hd8;
  localparam logic [7:0] SUB_HIGH_LAST = 8'hdb;

  // Key values expected with the SMART opcode
  localparam logic [7:0] KEY_CYL_LOW = 8'h4f;
  localparam logic [7:0] KEY_CYL_HIGH = 8'hc2;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [11:0] OFS_FEATURE = 12'h000;
  localparam logic [11:0] OFS_SEC_COUNT = 12'h004;
  localparam logic [11:0] OFS_SEC_NUMBER = 12'h008;
  localparam logic [11:0] OFS_CYL_LOW = 12'h00c;
  localparam logic [11:0] OFS_CYL_HIGH = 12'h010;
  localparam logic [11:0] OFS_TARGET = 12'h014;
  localparam logic [11:0] OFS_OPCODE = 12'h018;
  localparam logic [11:0] OFS_STATUS = 12'h01c;
  localparam logic [11:0] OFS_ERROR = 12'h020;
  localparam logic [11:0] OFS_DATA = 12'h024;
  localparam logic [11:0] OFS_DEVCTL = 12'h028;

  // Field positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ERR_ABORT = 2;
  localparam int TGT_DEV = 4;
  localparam int CTL_SRST = 2;

  // Values after reset or abort, and bus answers
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ERR_ABORT_VAL = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Sector transfer: 512 bytes moved as 32-bit words
  localparam int SECTOR_BYTES = 512;
  localparam logic [7:0] SECTOR_WORDS = 8'(SECTOR_BYTES / 4);
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    ASD_IDLE,
    ASD_SPIN_DOWN,
    ASD_SLEEP,
    ASD_SAVE,
    ASD_FETCH,
    ASD_STREAM
  } asd_state_e;

  // True for every subcommand code that the dispatcher accepts
  function automatic logic asd_valid_sub(input logic [7:0] code);
    asd_valid_sub = (code >= SUB_READ_VALUES && code <= SUB_LOW_LAST) ||
                    (code >= SUB_HIGH_FIRST && code <= SUB_HIGH_LAST);
  endfunction
endpackage

/* File: logic/asd_sync.sv */
// Two-flop synchroniser for a level arriving from a pin
`timescale 1ns/10ps
module asd_sync (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic meta;
    logic stab;
  } asd_sync_s;

  asd_sync_s r;
  asd_sync_s next_r;

  // First flop feeds only the second
  always_comb begin
    next_r.meta = din;
    next_r.stab = r.meta;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign dout = r.stab;
endmodule

/* File: logic/asd_fifo.sv */
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/10ps
module asd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } asd_fifo_s;

  asd_fifo_s r;
  asd_fifo_s next_r;
  logic push;
  logic pop;

  assign in_ready = (r.count != (AW+1)'(DEPTH));
  assign out_valid = (r.count != '0);
  assign out_data = r.mem[r.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at the depth, which need not be a power of two
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wr_ptr] = in_data;
      next_r.wr_ptr = (r.wr_ptr == AW'(DEPTH - 1)) ? '0 : r.wr_ptr + AW'(1);
    end
    if (pop) begin
      next_r.rd_ptr = (r.rd_ptr == AW'(DEPTH - 1)) ? '0 : r.rd_ptr + AW'(1);
    end
    next_r.count = r.count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      next_r.wr_ptr = '0;
      next_r.rd_ptr = '0;
      next_r.count = '0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else if (ce) begin
      r <= next_r;
    end
  end
endmodule

/* File: tb/asd_far_model.sv */
// Far-side model: spindle motor, attribute store and sector memory
`timescale 1ns/10ps
module asd_far_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic park,
  input wire logic spindle_stop,
  output logic spindle_stopped,
  input wire logic attr_save_req,
  output logic attr_save_done,
  input wire logic thr_fetch_req,
  output logic thr_fetch_done,
  input wire logic sector_rd_en,
  input wire logic sector_sel,
  input wire logic [6:0] sector_rd_addr,
  output logic [31:0] sector_rd_data,
  output int saves,
  output int fetches
);
  int spin;
  int wait_cnt;
  // Motor coasts 20 cycles before it reads stopped; park holds it stopped
  assign spindle_stopped = park || spin == 20;
  // Slow answers, and data that is only valid the cycle after the strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      spin <= 0;
      wait_cnt <= 0;
      attr_save_done <= 1'b0;
      thr_fetch_done <= 1'b0;
      sector_rd_data <= 32'h0;
      saves <= 0;
      fetches <= 0;
    end else begin
      spin <= !spindle_stop ? 0 : (spin < 20 ? spin + 1 : spin);
      wait_cnt <= (attr_save_req || thr_fetch_req) ? wait_cnt + 1 : 0;
      attr_save_done <= attr_save_req && wait_cnt == 4;
      thr_fetch_done <= thr_fetch_req && wait_cnt == 4;
      saves <= saves + int'(attr_save_req && wait_cnt == 4);
      fetches <= fetches + int'(thr_fetch_req && wait_cnt == 4);
      // Stale data is inverted so a late capture cannot pass by luck
      sector_rd_data <= sector_rd_en ? {15'h0, sector_sel, 9'h0, sector_rd_addr} : ~sector_rd_data;
    end
  end
endmodule

/* File: tb/asd_core_tb_top.sv */
// Self-checking bench for the sleep and SMART dispatcher
`timescale 1ns/10ps
module asd_core_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic park = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, sector_rd_data, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, spindle_stopped, spindle_stop;
  logic interface_inactive, attr_save_req, attr_save_done, thr_fetch_req, thr_fetch_done;
  logic sector_rd_en, sector_sel;
  logic [6:0] sector_rd_addr;
  logic [1:0] bresp, rresp, resp;
  int saves, fetches;
  int err_total = 0;
  int samples_checked = 0;

  asd_core i_asd_core (.ref_clk, .reset_n, .ce(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .spindle_stopped, .spindle_stop, .interface_inactive,
    .attr_save_req, .attr_save_done, .thr_fetch_req, .thr_fetch_done, .sector_rd_en,
    .sector_sel, .sector_rd_addr, .sector_rd_data);
  asd_far_model i_asd_far_model (.ref_clk, .reset_n, .park, .spindle_stop,
    .spindle_stopped, .attr_save_req, .attr_save_done, .thr_fetch_req, .thr_fetch_done,
    .sector_rd_en, .sector_sel, .sector_rd_addr, .sector_rd_data, .saves, .fetches);

  // Free-running 20 MHz clock
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One AXI4-Lite write; each valid drops at the edge it is taken
  task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    awaddr <= {20'h0, a};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'h3;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    araddr <= {20'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    r = 2'h3;
    v = 32'hx;
    for (n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        v = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic w(input logic [11:0] a, input logic [7:0] v);
    wr(a, v, resp);
    chk("bresp", 32'(resp), 32'(asd_pkg::RESP_OKAY));
  endtask

  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    rd(a, d, resp);
    chk("rresp", 32'(resp), 32'(asd_pkg::RESP_OKAY));
    chk(name, d, exp);
  endtask

  // Task-file setup: subcommand goes in before the opcode
  task automatic cmd(input logic [7:0] f, input logic [7:0] cl, input logic [7:0] op);
    w(asd_pkg::OFS_FEATURE, f);
    w(asd_pkg::OFS_CYL_LOW, cl);
    w(asd_pkg::OFS_CYL_HIGH, asd_pkg::KEY_CYL_HIGH);
    w(asd_pkg::OFS_TARGET, 8'h00);
    w(asd_pkg::OFS_OPCODE, op);
  endtask

  task automatic t_regs;
    rchk("idle st", asd_pkg::OFS_STATUS, 32'h50);
    rchk("idle err", asd_pkg::OFS_ERROR, 32'h0);
    wr(12'h02c, 8'h01, resp);
    chk("bad wr", 32'(resp), 32'(asd_pkg::RESP_SLVERR));
    rd(12'h031, d, resp);
    chk("bad rd", 32'(resp), 32'(asd_pkg::RESP_SLVERR));
  endtask

  // Whole sector drained through the data port, polling the data request bit
  task automatic t_stream(input logic [7:0] sub, input logic sel);
    int i, n, base;
    base = sel ? fetches : saves;
    cmd(sub, asd_pkg::KEY_CYL_LOW, asd_pkg::OPC_SMART);
    for (i = 0; i < 128; i++) begin
      n = 0;
      do begin
        rd(asd_pkg::OFS_STATUS, d, resp);
        n++;
      end while (!d[asd_pkg::ST_DRQ] && n < 60);
      if (i == 0) chk("prep", 32'((sel ? fetches : saves) - base), 1);
      rd(asd_pkg::OFS_DATA, d, resp);
      chk("word", d, {15'h0, sel, 9'h0, 7'(i)});
    end
    rchk("done st", asd_pkg::OFS_STATUS, 32'h50);
  endtask

  // Codes CFh-DCh except D0h and D1h, a bad key, a foreign opcode and another device
  task automatic t_codes;
    int f;
    logic ab;
    for (f = 'hcf; f <= 'hdc; f++) begin
      if (f == 'hd0 || f == 'hd1) continue;
      ab = f < 'hd2 || f == 'hd7 || f > 'hdb;
      cmd(8'(f), asd_pkg::KEY_CYL_LOW, asd_pkg::OPC_SMART);
      rchk("sub err", asd_pkg::OFS_ERROR, ab ? 32'h04 : 32'h0);
      rchk("sub st", asd_pkg::OFS_STATUS, ab ? 32'h51 : 32'h50);
    end
    cmd(8'hd2, 8'h4e, asd_pkg::OPC_SMART);
    rchk("key err", asd_pkg::OFS_ERROR, 32'h04);
    cmd(8'hd2, asd_pkg::KEY_CYL_LOW, 8'h20);
    rchk("opc err", asd_pkg::OFS_ERROR, 32'h04);
    w(asd_pkg::OFS_TARGET, 8'h10);
    w(asd_pkg::OFS_OPCODE, asd_pkg::OPC_SMART);
    rchk("tgt err", asd_pkg::OFS_ERROR, 32'h04);
  endtask

  // Sleep entry with a spinning or parked motor, then wake by soft or hard reset
  task automatic t_sleep(input logic [7:0] op, input logic pk, input logic hw);
    int n;
    park <= pk;
    cmd(8'h11, 8'h00, op);
    for (n = 0; n < 100 && interface_inactive !== 1'b1; n++) @(posedge ref_clk);
    chk("motor", {spindle_stop, spindle_stopped}, 2'b11);
    chk("delay", 32'(pk ? n < 8 : n >= 19), 1);
    rchk("sleep st", asd_pkg::OFS_STATUS, 32'h0);
    w(asd_pkg::OFS_FEATURE, 8'h33);
    rchk("sleep wr", asd_pkg::OFS_FEATURE, 32'h11);
    chk("asleep", 32'(interface_inactive), 1);
    if (hw) begin
      @(posedge ref_clk);
      reset_n <= 1'b0;
      @(posedge ref_clk);
      reset_n <= 1'b1;
    end else begin
      w(asd_pkg::OFS_DEVCTL, 8'h04);
      w(asd_pkg::OFS_DEVCTL, 8'h00);
    end
    park <= 1'b0;
    rchk("wake st", asd_pkg::OFS_STATUS, 32'h50);
    chk("awake", 32'(interface_inactive), 0);
  endtask

  // Main sequence after two cycles of reset
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    t_stream(asd_pkg::SUB_READ_VALUES, 1'b0);
    t_stream(asd_pkg::SUB_READ_THRESH, 1'b1);
    t_codes();
    t_sleep(asd_pkg::OPC_SLEEP_A, 1'b0, 1'b0);
    t_sleep(asd_pkg::OPC_SLEEP_B, 1'b1, 1'b1);
    print_verdict();
  end

  // Watchdog: the run needs about 2100 cycles
  initial begin
    #(50 * 40000);
    err_total++;
    print_verdict();
  end
endmodule
